// ### common/serial_pins_regs.svh
/*
 * Register offsets, field positions, reset values and pin timing for the serial pin block.
 * Assumes inclusion from the package and the design modules by bare name.
 */
`ifndef SERIAL_PINS_REGS_SVH
`define SERIAL_PINS_REGS_SVH

// APB byte addresses of the block's registers.
`define ADDR_STRAP        12'h000
`define ADDR_PORT_A_CTRL  12'h004
`define ADDR_PORT_A_STAT  12'h008
`define ADDR_PORT_B_CTRL  12'h00C
`define ADDR_PORT_B_STAT  12'h010
`define ADDR_PNP_BASE     12'h020
`define ADDR_PNP_LAST     12'h044
`define ADDR_EFE_PORT     12'h048
`define ADDR_TX_DATA      12'h04C

// Strap register field positions.
`define STRAP_EFE_BIT     0
`define STRAP_PNP_BIT     2

// Control register fields: bit 0 terminal ready, bit 1 request to send, bit 2 serial out.
`define CTRL_DTR_BIT      0
`define CTRL_RTS_BIT      1
`define CTRL_SOUT_BIT     2

// Handshake status fields; clear to send sits at bit 4.
`define STAT_SIN_BIT      0
`define STAT_RI_BIT       1
`define STAT_DCD_BIT      2
`define STAT_DSR_BIT      3
`define STAT_CTS_BIT      4

// Extended-functions enable port addresses chosen by the address strap.
`define EFE_ADDR_LOW      12'h250
`define EFE_ADDR_HIGH     12'h3F0

// Number of plug-and-play configuration registers in the range.
`define PNP_COUNT         10

// Default for every plug-and-play register; the floppy register's default enables it.
`define PNP_DEFAULT       8'h01

// Hold count loaded after reset release; the hold phase lasts this many cycles plus one before the pins are handed back.
`define STRAP_HOLD_CYCLES 4

`endif

// ### common/serial_pins_pkg.sv
/*
 * Types shared by the serial pin block.
 * Assumes the register header is on the include path.
 */
package serial_pins_pkg;
	`include "serial_pins_regs.svh"

	// Phase of the strap sequence after reset.
	typedef enum logic [1:0]
	{
		PH_SAMPLE = 2'b00,
		PH_HOLD   = 2'b01,
		PH_RUN    = 2'b10
	} strap_phase_t;

	// Modem line levels of one port, all as seen on the pins.
	typedef struct packed
	{
		logic sin;
		logic ri_n;
		logic dcd_n;
		logic dsr_n;
		logic cts_n;
	} modem_in_t;
endpackage

// ### common/modem_lines_if.sv
/*
 * Carries one port's synchronised modem input levels from the sampler to the top.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface modem_lines_if;
	import serial_pins_pkg::*;
	modem_in_t lines; // Synchronised line levels.
	modport src (output lines);
	modport dst (input lines);
endinterface
`default_nettype wire

// ### rtl/modem_sync.sv
/*
 * Two-flop synchroniser for one port's modem and serial input pins.
 * Assumes asynchronous pins and the block clock.
 */
`timescale 1ns/10ps
`default_nettype none
module modem_sync
(
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire serial_pins_pkg::modem_in_t pins,
	modem_lines_if.src                     out
);
	import serial_pins_pkg::*;

	// Both stages of the synchroniser in one state record.
	typedef struct packed
	{
		modem_in_t s1;
		modem_in_t s2;
	} sync_state_t;

	sync_state_t st_q; // Registered state.
	sync_state_t st_d; // Next state.

	// Only the second stage reads the first; idle lines rest high.
	always_comb
	begin
		st_d    = st_q;
		st_d.s1 = pins;
		st_d.s2 = st_q.s1;
	end

	// Register the stages; idle is all ones.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= '1;
		else
			st_q <= st_d;
	end

	assign out.lines = st_q.s2;
endmodule
`default_nettype wire

// ### rtl/serial_pins.sv
/*
 * Serial port pin block: modem-control lines of ports A and B, the port A
 * power-on straps, the plug-and-play reset images and an APB register file.
 * Assumes a 20 MHz pclk, an APB master, and that master_reset_in is an
 * asynchronous pin level held high for at least a few clocks.
 */
`timescale 1ns/10ps
`default_nettype none
`include "serial_pins_regs.svh"

module serial_pins
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        master_reset_in,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire serial_pins_pkg::modem_in_t port_a_in,
	input  wire serial_pins_pkg::modem_in_t port_b_in,
	input  wire logic        port_a_terminal_ready_in,
	input  wire logic        port_a_request_send_in,
	input  wire logic        port_a_serial_out_in,
	output logic             port_a_terminal_ready,
	output logic             port_a_terminal_ready_oe,
	output logic             port_a_request_send,
	output logic             port_a_request_send_oe,
	output logic             port_a_serial_out,
	output logic             port_a_serial_out_oe,
	output logic             floppy_controller_enable,
	output logic      [11:0] extended_functions_enable_port,
	output logic       [7:0] port_b_rx_shift
);
	import serial_pins_pkg::*;

	localparam int PNP_N = `PNP_COUNT; // Registers in the plug-and-play range.

	// Block state in one record, apart from in_run_q, efe_q and the modem synchronisers.
	typedef struct packed
	{
		logic [1:0]         mr_sync;   // Master reset two-flop synchroniser.
		logic [1:0]         sa_dtr;    // Terminal ready strap synchroniser.
		logic [1:0]         sa_rts;    // Request to send strap synchroniser.
		logic [1:0]         sa_sout;   // Serial out strap synchroniser.
		strap_phase_t       phase;     // Strap sequence phase.
		logic [2:0]         hold_cnt;  // Cycles left before pins are handed back.
		logic               efe_sel;   // Address-select strap bit.
		logic               pnp_sel;   // Plug-and-play default strap bit.
		logic               fdc_strap; // Floppy enable strap.
		logic [2:0]         ctrl_a;    // Port A line controls, active low on pins.
		logic [2:0]         ctrl_b;    // Port B line controls, kept for software.
		logic [PNP_N*8-1:0] pnp;       // Plug-and-play register images.
		logic [7:0]         rx_b;      // Port B received bit history.
		logic [31:0]        rdata;     // APB read data.
		logic               ready;     // APB ready.
		logic               err;       // APB error.
	} blk_state_t;

	blk_state_t st_q; // Registered state.
	blk_state_t st_d; // Next state.

	modem_lines_if lines_a ();
	modem_lines_if lines_b ();

	// Port A and port B modem inputs pass two flops before use.
	modem_sync sync_a
	(
		.pclk    (pclk),
		.presetn (presetn),
		.pins    (port_a_in),
		.out     (lines_a.src)
	);

	modem_sync sync_b
	(
		.pclk    (pclk),
		.presetn (presetn),
		.pins    (port_b_in),
		.out     (lines_b.src)
	);

	// Register-file images of the plug-and-play range under each strap choice.
	logic [PNP_N*8-1:0] pnp_reset_img; // Value loaded when reset releases.

	genvar gi;
	generate
		for (gi = 0; gi < PNP_N; gi = gi + 1)
		begin : g_pnp
			// Index 0 is the floppy register, which its own strap can clear too.
			if (gi == 0)
			begin : g_fdc
				assign pnp_reset_img[gi*8 +: 8] =
					(st_q.pnp_sel && st_q.fdc_strap) ? `PNP_DEFAULT : 8'h00;
			end
			else
			begin : g_other
				assign pnp_reset_img[gi*8 +: 8] = st_q.pnp_sel ? `PNP_DEFAULT : 8'h00;
			end
		end
	endgenerate

	logic       apb_acc;  // Access phase of a transfer.
	logic [4:0] stat_a;   // Port A handshake status.
	logic [4:0] stat_b;   // Port B handshake status.
	logic [3:0] pnp_idx;  // Plug-and-play index decoded from the address.
	logic       in_run;   // Strap sequence finished.

	// Status words give the line levels as seen; clear to send lands on bit 4.
	always_comb
	begin
		stat_a = {lines_a.lines.cts_n, lines_a.lines.dsr_n, lines_a.lines.dcd_n,
			lines_a.lines.ri_n, lines_a.lines.sin};
		stat_b = {lines_b.lines.cts_n, lines_b.lines.dsr_n, lines_b.lines.dcd_n,
			lines_b.lines.ri_n, lines_b.lines.sin};
		apb_acc = psel && penable && !st_q.ready;
		pnp_idx = 4'(paddr[11:2] - 10'(`ADDR_PNP_BASE >> 2));
		in_run  = (st_q.phase == PH_RUN);
	end

	// Next-state logic: reset sequencing, strap capture, and the APB slave.
	always_comb
	begin
		st_d          = st_q;
		st_d.mr_sync  = {st_q.mr_sync[0], master_reset_in};
		st_d.sa_dtr   = {st_q.sa_dtr[0], port_a_terminal_ready_in};
		st_d.sa_rts   = {st_q.sa_rts[0], port_a_request_send_in};
		st_d.sa_sout  = {st_q.sa_sout[0], port_a_serial_out_in};
		st_d.ready    = 1'b0;
		st_d.err      = 1'b0;
		st_d.rx_b     = {st_q.rx_b[6:0], lines_b.lines.sin};

		if (st_q.mr_sync[1])
		begin
			// Master reset held: keep pins released and keep sampling straps.
			st_d.phase     = PH_SAMPLE;
			st_d.efe_sel   = st_q.sa_dtr[1];
			st_d.pnp_sel   = st_q.sa_rts[1];
			st_d.fdc_strap = st_q.sa_sout[1];
			st_d.ctrl_a    = 3'b111;
			st_d.ctrl_b    = 3'b111;
		end
		else
		begin
			case (st_q.phase)
				PH_SAMPLE:
				begin
					// Release seen: strap sampling stops; from here on only APB strap writes change efe_sel and pnp_sel.
					st_d.phase    = PH_HOLD;
					st_d.hold_cnt = 3'(`STRAP_HOLD_CYCLES);
					st_d.pnp      = pnp_reset_img;
				end
				PH_HOLD:
				begin
					// Give the external pull resistors time before driving the pins.
					if (st_q.hold_cnt == 3'h0)
						st_d.phase = PH_RUN;
					else
						st_d.hold_cnt = st_q.hold_cnt - 3'h1;
				end
				PH_RUN:
				begin
					st_d.phase = PH_RUN;
				end
				default:
				begin
					st_d.phase = PH_SAMPLE;
				end
			endcase

			// APB answers one cycle into the access phase.
			if (apb_acc)
			begin
				st_d.ready = 1'b1;
				st_d.rdata = 32'h0000_0000;
				if (pwrite)
				begin
					if (paddr == `ADDR_STRAP)
					begin
						st_d.efe_sel = pwdata[`STRAP_EFE_BIT];
						st_d.pnp_sel = pwdata[`STRAP_PNP_BIT];
					end
					else if (paddr == `ADDR_PORT_A_CTRL)
						st_d.ctrl_a = pwdata[2:0];
					else if (paddr == `ADDR_PORT_B_CTRL)
						st_d.ctrl_b = pwdata[2:0];
					else if (paddr >= `ADDR_PNP_BASE && paddr <= `ADDR_PNP_LAST
						&& paddr[1:0] == 2'b00)
						st_d.pnp[pnp_idx*8 +: 8] = pwdata[7:0];
					else if (paddr == `ADDR_TX_DATA)
						st_d.ctrl_a[`CTRL_SOUT_BIT] = pwdata[0];
					else if (paddr != `ADDR_PORT_A_STAT && paddr != `ADDR_PORT_B_STAT
						&& paddr != `ADDR_EFE_PORT)
						st_d.err = 1'b1;
				end
				else
				begin
					if (paddr == `ADDR_STRAP)
					begin
						st_d.rdata[`STRAP_EFE_BIT] = st_q.efe_sel;
						st_d.rdata[`STRAP_PNP_BIT] = st_q.pnp_sel;
					end
					else if (paddr == `ADDR_PORT_A_CTRL)
						st_d.rdata[2:0] = st_q.ctrl_a;
					else if (paddr == `ADDR_PORT_A_STAT)
						st_d.rdata[4:0] = stat_a;
					else if (paddr == `ADDR_PORT_B_CTRL)
						st_d.rdata[2:0] = st_q.ctrl_b;
					else if (paddr == `ADDR_PORT_B_STAT)
						st_d.rdata[4:0] = stat_b;
					else if (paddr >= `ADDR_PNP_BASE && paddr <= `ADDR_PNP_LAST
						&& paddr[1:0] == 2'b00)
						st_d.rdata[7:0] = st_q.pnp[pnp_idx*8 +: 8];
					else if (paddr == `ADDR_EFE_PORT)
						st_d.rdata[11:0] = st_q.efe_sel ? `EFE_ADDR_HIGH : `EFE_ADDR_LOW;
					else
						st_d.err = 1'b1;
				end
			end
		end
	end

	// Register stage for the state record; reset leaves straps at their pull defaults.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q           <= '0;
			st_q.mr_sync   <= 2'b11;
			st_q.phase     <= PH_SAMPLE;
			st_q.pnp_sel   <= 1'b1;
			st_q.fdc_strap <= 1'b1;
			st_q.ctrl_a    <= 3'b111;
			st_q.ctrl_b    <= 3'b111;
		end
		else
			st_q <= st_d;
	end

	// Outputs come straight from registers, the pin enables one cycle behind the phase; pins are released until the sequence ends.
	logic in_run_q; // Registered copy of the run phase for the output enables.
	logic [11:0] efe_q; // Registered extended-functions port address.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			in_run_q <= 1'b0;
			efe_q    <= `EFE_ADDR_LOW;
		end
		else
		begin
			in_run_q <= in_run;
			efe_q    <= st_d.efe_sel ? `EFE_ADDR_HIGH : `EFE_ADDR_LOW;
		end
	end

	assign prdata                         = st_q.rdata;
	assign pready                         = st_q.ready;
	assign pslverr                        = st_q.err;
	assign port_a_terminal_ready          = st_q.ctrl_a[`CTRL_DTR_BIT];
	assign port_a_request_send            = st_q.ctrl_a[`CTRL_RTS_BIT];
	assign port_a_serial_out              = st_q.ctrl_a[`CTRL_SOUT_BIT];
	assign port_a_terminal_ready_oe       = in_run_q;
	assign port_a_request_send_oe         = in_run_q;
	assign port_a_serial_out_oe           = in_run_q;
	assign floppy_controller_enable       = st_q.pnp[0];
	assign extended_functions_enable_port = efe_q;
	assign port_b_rx_shift                = st_q.rx_b;
endmodule
`default_nettype wire

// ### sim/serial_pins_checker.sv
/* Assertions on the serial pin block's APB answers, pin drives and straps.
   Assumes a bind to serial_pins and the single pclk domain. */
`timescale 1ns/10ps
`default_nettype none
`include "serial_pins_regs.svh"
module serial_pins_checker
(
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic                       master_reset_in,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [11:0]                paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire serial_pins_pkg::modem_in_t port_a_in,
	input wire logic                       port_a_terminal_ready,
	input wire logic                       port_a_terminal_ready_oe,
	input wire logic                       port_a_request_send,
	input wire logic                       port_a_request_send_oe,
	input wire logic                       port_a_serial_out_oe,
	input wire logic [11:0]                extended_functions_enable_port
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	property p_slverr; pslverr |-> pready; endproperty
	a_slverr: assert property (p_slverr) else $error("pslverr without pready");
	property p_access; pready |-> psel && penable; endproperty
	a_access: assert property (p_access) else $error("pready outside access phase");
	// Held master reset blocks both answers and pin drive.
	// The pin passes two flops, then the phase register and the enable register, so allow five held cycles.
	property p_mr_quiet; master_reset_in [*5] |-> !pready && !port_a_serial_out_oe; endproperty
	a_mr_quiet: assert property (p_mr_quiet) else $error("activity in master reset");
	property p_efe; extended_functions_enable_port inside {`EFE_ADDR_LOW, `EFE_ADDR_HIGH}; endproperty
	a_efe: assert property (p_efe) else $error("bad extended port address");
	property p_oe_same; port_a_terminal_ready_oe == port_a_request_send_oe
		&& port_a_request_send_oe == port_a_serial_out_oe; endproperty
	a_oe_same: assert property (p_oe_same) else $error("pin enables disagree");
	property p_ctrl; psel && pwrite && pready && paddr == `ADDR_PORT_A_CTRL |=>
		port_a_terminal_ready == $past(pwdata[0]) && port_a_request_send == $past(pwdata[1]);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control write not on pins");
	property p_cts; $stable(port_a_in.cts_n) [*5] ##0 (pready && !pwrite
		&& paddr == `ADDR_PORT_A_STAT) |-> prdata[4] == port_a_in.cts_n; endproperty
	a_cts: assert property (p_cts) else $error("status bit 4 differs from pin");
	c_ctrl: cover property (psel && pwrite && pready && paddr == `ADDR_PORT_A_CTRL);
	c_err: cover property (pslverr);
	c_high: cover property (extended_functions_enable_port == `EFE_ADDR_HIGH);
endmodule
bind serial_pins serial_pins_checker u_chk (.pclk, .presetn, .master_reset_in, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port_a_in,
	.port_a_terminal_ready, .port_a_terminal_ready_oe, .port_a_request_send,
	.port_a_request_send_oe, .port_a_serial_out_oe, .extended_functions_enable_port);
`default_nettype wire

// ### sim/modem_model.sv
/* Modem model: turns line events into pin levels, active low except sin, resolves strap pins.
   Assumes events ordered {cts,dsr,dcd,ri,sin} as in the status register. */
`timescale 1ns/10ps
`default_nettype none
module modem_model
(
	input  wire logic [4:0]                ev_a,
	input  wire logic [4:0]                ev_b,
	input  wire logic [2:0]                pull,
	input  wire logic [2:0]                drv,
	input  wire logic [2:0]                oe,
	output logic      [2:0]                pin,
	output serial_pins_pkg::modem_in_t     line_a,
	output serial_pins_pkg::modem_in_t     line_b
);
	logic [4:0] lv_a; // Pin levels, status order.
	logic [4:0] lv_b; // Pin levels, status order.
	// Ring, carrier, data set ready and clear to send are driven low while present.
	assign lv_a = ev_a ^ 5'h1E;
	assign lv_b = ev_b ^ 5'h1E;
	assign line_a = {lv_a[0], lv_a[1], lv_a[2], lv_a[3], lv_a[4]};
	assign line_b = {lv_b[0], lv_b[1], lv_b[2], lv_b[3], lv_b[4]};
	// A released pin settles to its strap resistor level.
	assign pin = (oe & drv) | (~oe & pull);
endmodule
`default_nettype wire

// ### sim/serial_pins_bench.sv
/* Self-checking bench for the serial pin block over APB.
   Assumes the block's one-cycle registered APB answer. */
`timescale 1ns/10ps
`default_nettype none
`include "serial_pins_regs.svh"
`define CHK(g, e) compares++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end
module serial_pins_bench;
	import serial_pins_pkg::*;
	logic pclk = 0, presetn = 0, mr = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = 12'h000, efe;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [4:0] ev_a = 5'h00, ev_b = 5'h00;
	logic [2:0] pull = 3'h6, drv, oe, pin;
	logic [7:0] rx;
	logic fdc, er;
	modem_in_t la, lb;
	int compares = 0, miscompares = 0, cycles = 0;
	always #25 pclk = ~pclk;
	modem_model u_mod (.ev_a(ev_a), .ev_b(ev_b), .pull(pull), .drv(drv), .oe(oe),
		.pin(pin), .line_a(la), .line_b(lb));
	serial_pins u_dut (.pclk(pclk), .presetn(presetn), .master_reset_in(mr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port_a_in(la), .port_b_in(lb),
		.port_a_terminal_ready_in(pin[0]), .port_a_request_send_in(pin[1]),
		.port_a_serial_out_in(pin[2]), .port_a_terminal_ready(drv[0]),
		.port_a_terminal_ready_oe(oe[0]), .port_a_request_send(drv[1]),
		.port_a_request_send_oe(oe[1]), .port_a_serial_out(drv[2]),
		.port_a_serial_out_oe(oe[2]), .floppy_controller_enable(fdc),
		.extended_functions_enable_port(efe), .port_b_rx_shift(rx));
	// One APB transfer; request is held until pready is sampled high.
	// Only the bench timeout ends a wait that never sees pready.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		`CHK(rd, e)
	endtask
	// Master reset with the given strap resistors, then release.
	task mreset(input logic [2:0] s);
		pull <= s; mr <= 1;
		repeat (10) @(posedge pclk);
		`CHK(oe, 3'h0)
		mr <= 0;
		repeat (20) @(posedge pclk);
		`CHK(oe, 3'h7)
	endtask
	task print_verdict;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Cut a hang short.
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			miscompares++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		mreset(3'h6);
		`CHK(efe, `EFE_ADDR_LOW)
		rchk(`ADDR_STRAP, 32'h4);
		rchk(`ADDR_PNP_BASE, 32'h1);
		rchk(`ADDR_PNP_LAST, 32'h1);
		`CHK(fdc, 1'b1)
		apb(1, `ADDR_PORT_A_CTRL, 32'h0);
		`CHK(drv[1:0], 2'h0)
		apb(1, `ADDR_PORT_A_CTRL, 32'h3);
		`CHK(drv[1:0], 2'h3)
		for (int v = 0; v < 2; v++)
		begin
			apb(1, `ADDR_TX_DATA, v);
			`CHK(drv[2], v[0])
		end
		for (int k = 0; k < 5; k++)
		begin
			ev_a <= 5'h1 << k; ev_b <= 5'h1 << k;
			repeat (6) @(posedge pclk);
			rchk(`ADDR_PORT_A_STAT, {27'h0, (5'h1 << k) ^ 5'h1E});
			rchk(`ADDR_PORT_B_STAT, {27'h0, (5'h1 << k) ^ 5'h1E});
		end
		repeat (12) @(posedge pclk);
		`CHK(rx, 8'h00)
		ev_b <= 5'h1;
		repeat (12) @(posedge pclk);
		`CHK(rx, 8'hFF)
		apb(0, 12'h100, 32'h0);
		`CHK(er, 1'b1)
		apb(1, `ADDR_EFE_PORT, 32'h3F0);
		rchk(`ADDR_EFE_PORT, {20'h0, `EFE_ADDR_LOW});
		// Software may change the latched straps; the port address follows at once.
		apb(1, `ADDR_STRAP, 32'h1);
		`CHK(efe, `EFE_ADDR_HIGH)
		rchk(`ADDR_STRAP, 32'h1);
		rchk(`ADDR_PNP_BASE, 32'h1);
		apb(1, `ADDR_PNP_BASE + 12'h004, 32'h5A);
		rchk(`ADDR_PNP_BASE + 12'h004, 32'h5A);
		apb(1, 12'h100, 32'h1);
		`CHK(er, 1'b1)
		mreset(3'h1);
		`CHK(efe, `EFE_ADDR_HIGH)
		rchk(`ADDR_STRAP, 32'h1);
		rchk(`ADDR_PNP_BASE, 32'h0);
		rchk(`ADDR_PNP_LAST, 32'h0);
		`CHK(fdc, 1'b0)
		print_verdict();
	end
endmodule
`default_nettype wire
